// ===== verilog/lsb_alu_consts.vh
// Purpose: constants for the logic, shift and bit datapath
// Assumes: byte operands, 5-bit operation code
// Notes: operation codes are local encodings of this block
`ifndef LSB_ALU_CONSTS_VH
`define LSB_ALU_CONSTS_VH
`define LSB_OP_WIDTH 5
`define LSB_OP_AND 5'h00
`define LSB_OP_OR 5'h01
`define LSB_OP_XOR 5'h02
`define LSB_OP_NOT 5'h03
`define LSB_OP_ASL 5'h04
`define LSB_OP_ASR 5'h05
`define LSB_OP_LSL 5'h06
`define LSB_OP_LSR 5'h07
`define LSB_OP_ROL 5'h08
`define LSB_OP_ROR 5'h09
`define LSB_OP_RCL 5'h0A
`define LSB_OP_RCR 5'h0B
`define LSB_OP_SET_BIT 5'h0C
`define LSB_OP_CLR_BIT 5'h0D
`define LSB_OP_BINV 5'h0E
`define LSB_OP_TST_BIT 5'h0F
`define LSB_OP_CAND 5'h10
`define LSB_OP_CAND_INV 5'h11
`define LSB_OP_COR 5'h12
`define LSB_OP_COR_INV 5'h13
`define LSB_OP_CXOR 5'h14
`define LSB_OP_CXOR_INV 5'h15
`define LSB_OP_LD_BIT 5'h16
`define LSB_OP_LD_BIT_INV 5'h17
`define LSB_OP_ST_BIT 5'h18
`define LSB_OP_ST_BIT_INV 5'h19
`define LSB_RESET_BYTE 8'h00
`define LSB_RESET_FLAG 1'h0
`define LSB_ST_IDLE 2'h0
`define LSB_ST_READ 2'h1
`define LSB_ST_WAIT 2'h2
`define LSB_ST_WRITE 2'h3
`endif

// ===== verilog/lsb_alu.v
// Purpose: byte logic, shift, rotate and bit-manipulation datapath
// Assumes: operands held stable from start until done; one op at a time
// Notes: memory operand bit ops read, then write back at one address only for byte-writing ops
`timescale 1ns/1ps
`include "lsb_alu_consts.vh"
module lsb_alu #(
  parameter DATA_WIDTH = 8,
  parameter ADDR_WIDTH = 16
) (
  input wire ref_clk,
  input wire rst,
  input wire start,
  input wire [4:0] op,
  input wire use_imm,
  input wire use_mem,
  input wire pos_from_reg,
  input wire [7:0] dest_data,
  input wire [7:0] source_register,
  input wire [7:0] imm_data,
  input wire [2:0] imm_pos,
  input wire [ADDR_WIDTH-1:0] mem_addr_in,
  input wire carry_in,
  input wire zero_in,
  input wire [7:0] mem_rdata,
  input wire mem_rvalid,
  output reg [7:0] result,
  output reg result_we,
  output reg carry_out,
  output reg carry_we,
  output reg zero_out,
  output reg zero_we,
  output reg done,
  output reg busy,
  output reg bad_op,
  output reg mem_rd,
  output reg mem_wr,
  output reg [ADDR_WIDTH-1:0] mem_addr,
  output reg [7:0] mem_wdata
);

  reg [1:0] state;
  reg [7:0] next_byte;
  reg next_carry;
  reg next_zero;
  reg wr_byte;
  reg wr_carry;
  reg wr_zero;
  reg illegal;
  reg [7:0] operand;
  reg [2:0] pos;
  reg sel;
  reg [7:0] other;

  // immediate-only ops reject a register-supplied position
  function imm_only;
    input [4:0] code;
    begin
      imm_only = (code == `LSB_OP_CAND_INV) || (code == `LSB_OP_COR_INV) ||
        (code == `LSB_OP_CXOR_INV) || (code == `LSB_OP_LD_BIT_INV) ||
        (code == `LSB_OP_ST_BIT_INV);
    end
  endfunction

  function is_bit_op;
    input [4:0] code;
    begin
      is_bit_op = (code >= `LSB_OP_SET_BIT) && (code <= `LSB_OP_ST_BIT_INV);
    end
  endfunction

  function [7:0] put_bit;
    input [7:0] val;
    input [2:0] p;
    input b;
    reg [7:0] tmp;
    begin
      tmp = val;
      tmp[p] = b;
      put_bit = tmp;
    end
  endfunction

  always @* begin
    operand = (state == `LSB_ST_WAIT) ? mem_rdata : dest_data;
    pos = pos_from_reg ? source_register[2:0] : imm_pos;
    sel = operand[pos];
    other = use_imm ? imm_data : source_register;
    next_byte = operand;
    next_carry = carry_in;
    next_zero = zero_in;
    wr_byte = 1'b0;
    wr_carry = 1'b0;
    wr_zero = 1'b0;
    illegal = 1'b0;
    if (is_bit_op(op) && imm_only(op) && pos_from_reg) begin
      illegal = 1'b1;
    end else begin
      case (op)
        `LSB_OP_AND: begin
          next_byte = operand & other;
          wr_byte = 1'b1;
        end
        `LSB_OP_OR: begin
          next_byte = operand | other;
          wr_byte = 1'b1;
        end
        `LSB_OP_XOR: begin
          next_byte = operand ^ other;
          wr_byte = 1'b1;
        end
        `LSB_OP_NOT: begin
          next_byte = ~operand;
          wr_byte = 1'b1;
        end
        `LSB_OP_ASL, `LSB_OP_LSL: begin
          next_byte = {operand[6:0], 1'b0};
          next_carry = operand[7];
          wr_byte = 1'b1;
          wr_carry = 1'b1;
        end
        `LSB_OP_ASR: begin
          next_byte = {operand[7], operand[7:1]};
          next_carry = operand[0];
          wr_byte = 1'b1;
          wr_carry = 1'b1;
        end
        `LSB_OP_LSR: begin
          next_byte = {1'b0, operand[7:1]};
          next_carry = operand[0];
          wr_byte = 1'b1;
          wr_carry = 1'b1;
        end
        `LSB_OP_ROL: begin
          next_byte = {operand[6:0], operand[7]};
          next_carry = operand[7];
          wr_byte = 1'b1;
          wr_carry = 1'b1;
        end
        `LSB_OP_ROR: begin
          next_byte = {operand[0], operand[7:1]};
          next_carry = operand[0];
          wr_byte = 1'b1;
          wr_carry = 1'b1;
        end
        `LSB_OP_RCL: begin
          next_byte = {operand[6:0], carry_in};
          next_carry = operand[7];
          wr_byte = 1'b1;
          wr_carry = 1'b1;
        end
        `LSB_OP_RCR: begin
          next_byte = {carry_in, operand[7:1]};
          next_carry = operand[0];
          wr_byte = 1'b1;
          wr_carry = 1'b1;
        end
        `LSB_OP_SET_BIT: begin
          next_byte = put_bit(operand, pos, 1'b1);
          wr_byte = 1'b1;
        end
        `LSB_OP_CLR_BIT: begin
          next_byte = put_bit(operand, pos, 1'b0);
          wr_byte = 1'b1;
        end
        `LSB_OP_BINV: begin
          next_byte = put_bit(operand, pos, ~sel);
          wr_byte = 1'b1;
        end
        `LSB_OP_TST_BIT: begin
          next_zero = ~sel;
          wr_zero = 1'b1;
        end
        `LSB_OP_CAND: begin
          next_carry = carry_in & sel;
          wr_carry = 1'b1;
        end
        `LSB_OP_CAND_INV: begin
          next_carry = carry_in & ~sel;
          wr_carry = 1'b1;
        end
        `LSB_OP_COR: begin
          next_carry = carry_in | sel;
          wr_carry = 1'b1;
        end
        `LSB_OP_COR_INV: begin
          next_carry = carry_in | ~sel;
          wr_carry = 1'b1;
        end
        `LSB_OP_CXOR: begin
          next_carry = carry_in ^ sel;
          wr_carry = 1'b1;
        end
        `LSB_OP_CXOR_INV: begin
          next_carry = carry_in ^ ~sel;
          wr_carry = 1'b1;
        end
        `LSB_OP_LD_BIT: begin
          next_carry = sel;
          wr_carry = 1'b1;
        end
        `LSB_OP_LD_BIT_INV: begin
          next_carry = ~sel;
          wr_carry = 1'b1;
        end
        `LSB_OP_ST_BIT: begin
          next_byte = put_bit(operand, pos, carry_in);
          wr_byte = 1'b1;
        end
        `LSB_OP_ST_BIT_INV: begin
          next_byte = put_bit(operand, pos, ~carry_in);
          wr_byte = 1'b1;
        end
        default: begin
          illegal = 1'b1;
        end
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state <= `LSB_ST_IDLE;
      result <= `LSB_RESET_BYTE;
      result_we <= 1'b0;
      carry_out <= `LSB_RESET_FLAG;
      carry_we <= 1'b0;
      zero_out <= `LSB_RESET_FLAG;
      zero_we <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
      bad_op <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= {ADDR_WIDTH{1'b0}};
      mem_wdata <= `LSB_RESET_BYTE;
    end else begin
      result_we <= 1'b0;
      carry_we <= 1'b0;
      zero_we <= 1'b0;
      done <= 1'b0;
      bad_op <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      case (state)
        `LSB_ST_IDLE: begin
          if (start && use_mem && is_bit_op(op) && !illegal) begin
            mem_addr <= mem_addr_in;
            mem_rd <= 1'b1;
            busy <= 1'b1;
            state <= `LSB_ST_WAIT;
          end else if (start) begin
            result <= next_byte;
            result_we <= wr_byte & ~illegal;
            carry_out <= next_carry;
            carry_we <= wr_carry & ~illegal;
            zero_out <= next_zero;
            zero_we <= wr_zero & ~illegal;
            bad_op <= illegal;
            done <= 1'b1;
          end
        end
        `LSB_ST_WAIT: begin
          if (mem_rvalid) begin
            carry_out <= next_carry;
            carry_we <= wr_carry;
            zero_out <= next_zero;
            zero_we <= wr_zero;
            result <= next_byte;
            if (wr_byte) begin
              mem_wdata <= next_byte;
              mem_wr <= 1'b1;
            end
            done <= 1'b1;
            busy <= 1'b0;
            state <= `LSB_ST_IDLE;
          end
        end
        default: begin
          busy <= 1'b0;
          state <= `LSB_ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== testbench/lsb_alu_monitor.sv
// Purpose: port assertions for the logic, shift and bit datapath
// Assumes: single clock, synchronous active-high reset
// Notes: bound to every lsb_alu instance below
`timescale 1ns/1ps
`include "lsb_alu_consts.vh"
module lsb_alu_monitor #(
  parameter ADDR_WIDTH = 16
) (
  input wire ref_clk,
  input wire rst,
  input wire start,
  input wire [4:0] op,
  input wire use_imm,
  input wire use_mem,
  input wire pos_from_reg,
  input wire [7:0] dest_data,
  input wire [7:0] source_register,
  input wire [2:0] imm_pos,
  input wire carry_in,
  input wire [ADDR_WIDTH-1:0] mem_addr_in,
  input wire mem_rvalid,
  input wire [7:0] result,
  input wire result_we,
  input wire carry_out,
  input wire carry_we,
  input wire zero_out,
  input wire zero_we,
  input wire done,
  input wire busy,
  input wire bad_op,
  input wire mem_rd,
  input wire [ADDR_WIDTH-1:0] mem_addr
);
  wire go = start && !busy;
  wire mem_bit = use_mem && op >= `LSB_OP_SET_BIT && op <= `LSB_OP_ST_BIT_INV;
  wire inv_op = op[0] && op >= `LSB_OP_CAND_INV && op <= `LSB_OP_ST_BIT_INV;
  wire sel = dest_data[imm_pos];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_reg_done: assert property (go && !mem_bit |=> done)
    else $error("register op did not finish next cycle");
  chk_mem_read: assert property (go && mem_bit && !pos_from_reg |=>
    mem_rd && busy && mem_addr == $past(mem_addr_in))
    else $error("memory read missing or at wrong address");
  chk_mem_finish: assert property (busy && mem_rvalid |=>
    done && !busy)
    else $error("memory op did not finish after read data");
  chk_and_reg: assert property (go && op == `LSB_OP_AND &&
    !use_imm |=>
    result_we && result == ($past(dest_data) & $past(source_register)))
    else $error("and result wrong");
  chk_not_byte: assert property (go && op == `LSB_OP_NOT |=>
    result_we && result == ~$past(dest_data))
    else $error("complement result wrong");
  chk_rcl_loop: assert property (go && op == `LSB_OP_RCL |=>
    carry_we && {carry_out, result} == {$past(dest_data), $past(carry_in)})
    else $error("rotate through carry wrong");
  chk_asr_sign: assert property (go && op == `LSB_OP_ASR |=>
    {result, carry_out} == {$past(dest_data[7]), $past(dest_data)})
    else $error("arithmetic right shift wrong");
  chk_test_zero: assert property (go && op == `LSB_OP_TST_BIT &&
    !use_mem && !pos_from_reg |=> zero_we && zero_out == !$past(sel))
    else $error("bit test zero flag wrong");
  chk_inv_refuse: assert property (go && inv_op && pos_from_reg |=>
    done && bad_op && !carry_we && !result_we && !mem_rd)
    else $error("register position accepted on immediate-only op");
endmodule
bind lsb_alu lsb_alu_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) u_mon (.ref_clk,
  .rst, .start, .op, .use_imm, .use_mem, .pos_from_reg, .dest_data,
  .source_register, .imm_pos, .carry_in, .mem_addr_in, .mem_rvalid, .result,
  .result_we, .carry_out, .carry_we, .zero_out, .zero_we, .done, .busy,
  .bad_op, .mem_rd, .mem_addr);

// ===== testbench/test_lsb_alu.sv
// Purpose: self-checking bench for the logic, shift and bit datapath
// Assumes: register ops answer next cycle, memory ops per handshake
// Notes: driver queues expected results, watcher checks them at done
`timescale 1ns/1ps
`include "lsb_alu_consts.vh"
module test_lsb_alu;
  reg ref_clk = 1'h0, rst = 1'h1, start = 1'h0, use_imm = 1'h0;
  reg use_mem = 1'h0, pos_from_reg = 1'h0, carry_in = 1'h0;
  reg zero_in = 1'h0, mem_rvalid = 1'h0;
  reg [4:0] op = 5'h00;
  reg [7:0] dest_data = 8'h00, source_register = 8'h00;
  reg [7:0] imm_data = 8'h00, mem_rdata = 8'h00;
  reg [2:0] imm_pos = 3'h0;
  reg [15:0] mem_addr_in = 16'h0000;
  wire [7:0] result, mem_wdata;
  wire [15:0] mem_addr;
  wire result_we, carry_out, carry_we, zero_out, zero_we;
  wire done, busy, bad_op, mem_rd, mem_wr;
  integer fails = 0, n_tests = 0, seed = 17, i, k;
  reg [14:0] q[$];
  reg [14:0] e;
  reg [31:0] r;
  always #10 ref_clk = ~ref_clk;
  lsb_alu dut_u (.ref_clk, .rst, .start, .op, .use_imm, .use_mem,
    .pos_from_reg, .dest_data, .source_register, .imm_data, .imm_pos,
    .mem_addr_in, .carry_in, .zero_in, .mem_rdata, .mem_rvalid, .result,
    .result_we, .carry_out, .carry_we, .zero_out, .zero_we, .done, .busy,
    .bad_op, .mem_rd, .mem_wr, .mem_addr, .mem_wdata);
  task chk(input [23:0] s, input [23:0] x);
    begin
      n_tests = n_tests + 1;
      if (s !== x) begin
        fails = fails + 1;
        $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // packs {mem, bad, write, carry we, zero we, zero, carry, byte}
  function [14:0] model(input [4:0] o, input [7:0] a, input [7:0] b,
      input [2:0] p, input c, input m, input pr);
    reg [7:0] y;
    reg nc, bt, bad;
    begin
      y = a;
      nc = c;
      bt = a[p];
      bad = o > 5'h19 || pr && o[0] && o > 5'h10;
      case (o)
        5'h00: y = a & b;
        5'h01: y = a | b;
        5'h02: y = a ^ b;
        5'h03: y = ~a;
        5'h04, 5'h06: {nc, y} = {a, 1'h0};
        5'h05: {y, nc} = {a[7], a};
        5'h07: {y, nc} = {1'h0, a};
        5'h08: {nc, y} = {a, a[7]};
        5'h09: {y, nc} = {a[0], a};
        5'h0A: {nc, y} = {a, c};
        5'h0B: {y, nc} = {c, a};
        5'h0C: y[p] = 1'h1;
        5'h0D: y[p] = 1'h0;
        5'h0E: y[p] = ~bt;
        5'h10, 5'h11: nc = c & (bt ^ o[0]);
        5'h12, 5'h13: nc = c | (bt ^ o[0]);
        5'h14, 5'h15: nc = c ^ bt ^ o[0];
        5'h16, 5'h17: nc = bt ^ o[0];
        5'h18, 5'h19: y[p] = c ^ o[0];
      endcase
      model = {m, 1'h1, 13'h0000};
      if (!bad) model = {m, 1'h0, o < 5'h0F || o > 5'h17,
        o > 5'h03 && o < 5'h0C || o > 5'h0F && o < 5'h18, o == 5'h0F,
        !bt, nc, y};
    end
  endfunction
  always @(posedge ref_clk) if (!rst && done !== 1'h0) begin
    if (q.size() == 0) chk(1'h1, 1'h0);
    else begin
      e = q.pop_front();
      chk({bad_op, e[14] ? mem_wr : result_we, carry_we, zero_we},
        e[13:10]);
      if (e[12]) chk(e[14] ? mem_wdata : result, e[7:0]);
      if (e[11]) chk(carry_out, e[8]);
      if (e[10]) chk(zero_out, e[9]);
    end
  end
  task issue(input [4:0] o, input m, input pr);
    begin
      @(posedge ref_clk);
      r = $random(seed);
      start <= 1'h1;
      op <= o;
      use_mem <= m;
      pos_from_reg <= pr;
      dest_data <= r[7:0];
      source_register <= r[15:8];
      imm_data <= r[23:16];
      imm_pos <= r[26:24];
      carry_in <= r[27];
      use_imm <= r[28];
      zero_in <= r[29];
      mem_addr_in <= r[31:16];
      q.push_back(model(o, m ? r[15:8] : r[7:0], r[28] ? r[23:16] : r[15:8],
        pr ? r[10:8] : r[26:24], r[27], m, pr));
      if (m) begin
        // start held one extra cycle while busy must be ignored
        repeat (2) @(posedge ref_clk);
        start <= 1'h0;
        chk({mem_rd, mem_addr}, {1'h1, r[31:16]});
        repeat (2) @(posedge ref_clk);
        mem_rvalid <= 1'h1;
        mem_rdata <= r[15:8];
        @(posedge ref_clk);
        mem_rvalid <= 1'h0;
        mem_rdata <= ~r[15:8];
        repeat (2) @(posedge ref_clk);
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    for (k = 0; k < 4; k = k + 1)
      for (i = 0; i < 32; i = i + 1)
        issue(i[4:0], 1'h0, k[0] & i[0]);
    for (i = 12; i < 26; i = i + 1)
      issue(i[4:0], 1'h1, 1'h0);
    @(posedge ref_clk);
    start <= 1'h0;
    repeat (3) @(posedge ref_clk);
    chk(q.size() != 0, 1'h0);
    close_out;
  end
  // whole run needs about 256 cycles
  initial begin
    #40000;
    fails = fails + 1;
    close_out;
  end
endmodule
